// ===== tb/lcr_fabric_model.sv
`timescale 1ns/100ps
module lcr_fabric_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [3:0] row_set,
  output logic      [3:0] row_cell_in,
  output logic      [3:0] ded_in,
  output logic      [1:0] ded_clk_pin
);
  // registered cells; free pins move every cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      row_cell_in <= 4'h0;
      ded_in      <= 4'h0;
      ded_clk_pin <= 2'h1;
    end else begin
      row_cell_in <= row_set;
      ded_in      <= ded_in + 4'h3;
      ded_clk_pin <= ~ded_clk_pin;
    end
  end
endmodule : lcr_fabric_model

// ===== tb/lcr_top_props.sv
`timescale 1ns/100ps
module lcr_top_props
  import lcr_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 clk_en,
  input wire logic [3:0]           lut_in,
  input wire logic [LCR_LUT_W-1:0] lut_mask,
  input wire logic                 cell_sync_en,
  input wire logic                 cell_group_ctrl_a,
  input wire logic                 cell_group_ctrl_b,
  input wire lcr_mode_e            cell_mode,
  input wire logic                 lut_out,
  input wire logic                 cell_q,
  input wire logic [3:0]           row_cell_in,
  input wire logic [35:0]          pcb_src_sel,
  input wire logic [11:0]          pcb_src_inv,
  input wire logic [3:0]           pin_oe_sel,
  input wire logic                 pin_oe_direct_use,
  input wire logic                 chip_rst_n,
  input wire logic [11:0]          pcb_bus,
  input wire logic                 pcb_alloc_err,
  input wire logic                 pin_q,
  input wire logic                 pin_oe_n
);
  logic row0_q;
  logic rowsel_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // line 0 expectation when fed by a row cell
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      row0_q   <= 1'b0;
      rowsel_q <= 1'b0;
    end else if (clk_en) begin
      row0_q   <= row_cell_in[pcb_src_sel[1:0]] ^ pcb_src_inv[0];
      rowsel_q <= pcb_src_sel[2];
    end
  end
  property p_lut; lut_out == lut_mask[lut_in]; endproperty
  a_lut: assert property (p_lut) else $error("lut output wrong");
  property p_cap;
    clk_en && cell_sync_en && !cell_group_ctrl_a && !cell_group_ctrl_b ##1
      !cell_group_ctrl_a && !cell_group_ctrl_b && $stable(cell_mode) |-> cell_q == $past(lut_out);
  endproperty
  a_cap: assert property (p_cap) else $error("cell capture wrong");
  property p_clr; cell_mode == LCR_MODE_CLR && (cell_group_ctrl_a || cell_group_ctrl_b) |-> !cell_q; endproperty
  a_clr: assert property (p_clr) else $error("cell not cleared");
  property p_pc;
    cell_mode == LCR_MODE_PRE_CLR && lut_in[3] && cell_group_ctrl_a && !cell_group_ctrl_b |-> cell_q;
  endproperty
  a_pc: assert property (p_pc) else $error("cell not preset");
  property p_ldc; cell_mode == LCR_MODE_LOAD_CLR && cell_group_ctrl_b |-> !cell_q; endproperty
  a_ldc: assert property (p_ldc) else $error("load clear failed");
  property p_ld; cell_mode == LCR_MODE_LOAD && cell_group_ctrl_a |-> cell_q == lut_in[3]; endproperty
  a_ld: assert property (p_ld) else $error("cell load wrong");
  property p_rst; !chip_rst_n && !$past(chip_rst_n) |-> !pin_q && pin_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("chip reset not obeyed");
  property p_err; !pin_oe_direct_use && pin_oe_sel >= 4'h8 |-> pcb_alloc_err; endproperty
  a_err: assert property (p_err) else $error("oe line overuse missed");
  property p_bus; rowsel_q |-> pcb_bus[0] == row0_q; endproperty
  a_bus: assert property (p_bus) else $error("bus line 0 wrong");
  c_cap: cover property (clk_en && cell_sync_en);
  c_rst: cover property (!chip_rst_n ##1 !chip_rst_n);
  c_err: cover property (pcb_alloc_err);
endmodule : lcr_top_props
bind lcr_top lcr_top_props u_props (.clk_sys, .nrst, .clk_en, .lut_in, .lut_mask, .cell_sync_en,
  .cell_group_ctrl_a, .cell_group_ctrl_b, .cell_mode, .lut_out, .cell_q, .row_cell_in, .pcb_src_sel,
  .pcb_src_inv, .pin_oe_sel, .pin_oe_direct_use, .chip_rst_n, .pcb_bus, .pcb_alloc_err, .pin_q, .pin_oe_n);

// ===== tb/lcr_top_tb_top.sv
`timescale 1ns/100ps
module lcr_top_tb_top;
  import lcr_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b0, cell_sync_en = 1'b1, ctl_a = 1'b0, ctl_b = 1'b0;
  logic [3:0] lut_in = 4'h0, row_set = 4'h0, oe_sel = 4'h0, ce_sel = 4'h0, clr_sel = 4'h4;
  logic [15:0] lut_mask = 16'h0;
  lcr_mode_e cell_mode = LCR_MODE_CLR;
  logic [35:0] src_sel = 36'h000005004;
  logic [11:0] src_inv = 12'h0;
  logic oe_du = 1'b1, oe_d = 1'b1, ce_du = 1'b1, ce_d = 1'b1, pin_d = 1'b0, chip_rst_n = 1'b1;
  logic [3:0] row_cell_in, ded_in;
  logic [1:0] ded_clk_pin;
  logic lut_out, cell_q, pcb_alloc_err, pin_q, pin_oe_n, q_m, d3;
  logic [1:0] e;
  int error_cnt = 0, compares = 0;
  always #5 clk_sys = ~clk_sys;
  lcr_fabric_model u_fab (.clk_sys, .nrst, .row_set, .row_cell_in, .ded_in, .ded_clk_pin);
  lcr_top u_dut (.clk_sys, .nrst, .clk_en, .lut_in, .lut_mask, .cell_sync_en, .cell_group_ctrl_a(ctl_a),
    .cell_group_ctrl_b(ctl_b), .cell_mode, .lut_out, .cell_q, .ded_in, .row_cell_in, .pcb_src_sel(src_sel),
    .pcb_src_inv(src_inv), .pin_oe_sel(oe_sel), .pin_ce_sel(ce_sel), .pin_clr_sel(clr_sel),
    .pin_oe_direct_use(oe_du), .pin_oe_direct(oe_d), .pin_ce_direct_use(ce_du), .pin_ce_direct(ce_d),
    .pin_clk_src(2'b00), .ded_clk_invert(1'b0), .ded_clk_pin, .pin_d, .chip_rst_n, .pcb_bus(),
    .pcb_alloc_err, .pin_q, .pin_out(), .pin_oe_n);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_pin(input logic v);
    for (int k = 0; k < 8 && pin_q !== v; k++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp(pin_q, v);
  endtask : wait_pin
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // {checked, value} after an async pulse on line a or b
  function automatic logic [1:0] exp_async(input int m, input logic d, input logic on_b);
    case (m)
      0: return 2'b10;
      1: return on_b ? 2'b00 : 2'b11;
      2: return on_b ? 2'b10 : 2'b11;
      3: return on_b ? 2'b10 : {1'b1, d};
      4: return on_b ? 2'b11 : {1'b1, d};
      default: return on_b ? 2'b00 : {1'b1, d};
    endcase
  endfunction : exp_async
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    q_m = 1'b0;
    void'($urandom(19));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      lut_mask <= 16'($urandom);
      lut_in <= 4'($urandom);
      clk_en <= 1'($urandom);
      #1;
      cmp(cell_q, q_m);
      cmp(lut_out, lut_mask[lut_in]);
      if (clk_en) q_m = lut_mask[lut_in];
    end
    for (int m = 0; m < 12; m++) begin
      d3 = (m < 6) ? 1'b1 : 1'($urandom);
      @(posedge clk_sys);
      clk_en <= 1'b0;
      cell_mode <= lcr_mode_e'(6'h01 << (m / 2));
      lut_in <= {d3, 3'h0};
      ctl_a <= !m[0];
      ctl_b <= m[0];
      #1;
      e = exp_async(m / 2, d3, m[0]);
      if (e[1]) cmp(cell_q, e[0]);
      @(posedge clk_sys);
      ctl_a <= 1'b0;
      ctl_b <= 1'b0;
    end
    clk_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      pin_d <= !pin_d;
      row_set <= 4'h0;
      repeat (3) @(posedge clk_sys);
      row_set <= 4'h1;
      wait_pin(pin_d);
      cmp(pin_oe_n, 1'b0);
    end
    @(posedge clk_sys);
    row_set <= 4'h2;
    wait_pin(1'b0);
    @(posedge clk_sys);
    row_set <= 4'h0;
    pin_d <= 1'b1;
    repeat (3) @(posedge clk_sys);
    row_set <= 4'h1;
    wait_pin(1'b1);
    @(posedge clk_sys);
    chip_rst_n <= 1'b0;
    wait_pin(1'b0);
    @(posedge clk_sys);
    #1;
    cmp(pin_oe_n, 1'b1);
    oe_du <= 1'b0;
    oe_sel <= 4'h8;
    @(posedge clk_sys);
    #1;
    cmp(pcb_alloc_err, 1'b1);
    oe_sel <= 4'h7;
    ce_du <= 1'b0;
    ce_sel <= 4'h6;
    @(posedge clk_sys);
    #1;
    cmp(pcb_alloc_err, 1'b1);
    ce_sel <= 4'h5;
    @(posedge clk_sys);
    #1;
    cmp(pcb_alloc_err, 1'b0);
    wrap_up();
  end
endmodule : lcr_top_tb_top

// ===== verilog/lcr_cell_ff.sv
`timescale 1ns/100ps
module lcr_cell_ff
  import lcr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic sync_en,
  input  wire logic d,
  lcr_ctrl_if.dst   ctl,
  output logic      q
);
  logic store_q;
  logic store_d;

  always_comb begin
    store_d = store_q;
    if (ce && sync_en) begin
      store_d = ctl.inv_io ? ~d : d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst or posedge ctl.async_set or posedge ctl.async_clr) begin
    if (!nrst) begin
      store_q <= LCR_CELL_RST_VAL;
    end else if (ctl.async_clr) begin
      store_q <= 1'b0;
    end else if (ctl.async_set) begin
      store_q <= 1'b1;
    end else begin
      store_q <= store_d;
    end
  end

  assign q = ctl.inv_io ? ~store_q : store_q;
endmodule : lcr_cell_ff

// ===== verilog/lcr_ctrl_if.sv
`timescale 1ns/100ps
interface lcr_ctrl_if;
  logic async_set;
  logic async_clr;
  logic inv_io;
  modport src (output async_set, output async_clr, output inv_io);
  modport dst (input async_set, input async_clr, input inv_io);
endinterface : lcr_ctrl_if

// ===== verilog/lcr_pkg.sv
package lcr_pkg;
  // logic cell asynchronous control modes, one-hot
  typedef enum logic [5:0] {
    LCR_MODE_CLR      = 6'h01,
    LCR_MODE_PRE      = 6'h02,
    LCR_MODE_PRE_CLR  = 6'h04,
    LCR_MODE_LOAD_CLR = 6'h08,
    LCR_MODE_LOAD_PRE = 6'h10,
    LCR_MODE_LOAD     = 6'h20
  } lcr_mode_e;

  localparam int LCR_LUT_W     = 16;
  localparam int LCR_PCB_W     = 12;
  localparam int LCR_MAX_OE    = 8;
  localparam int LCR_MAX_CE    = 6;
  localparam int LCR_MAX_CLK   = 2;
  localparam int LCR_MAX_CLR   = 2;
  localparam int LCR_PCB_SEL_W = 4;
  localparam int LCR_DED_IN_W  = 4;
  localparam int LCR_ROW_SRC_W = 4;
  localparam int LCR_SRC_SEL_W = 3;
  localparam logic LCR_CELL_RST_VAL = 1'b0;
  localparam logic LCR_PIN_RST_VAL  = 1'b0;
endpackage : lcr_pkg

// ===== verilog/lcr_top.sv
`timescale 1ns/100ps
module lcr_top
  import lcr_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire logic [3:0]               lut_in,
  input  wire logic [LCR_LUT_W-1:0]     lut_mask,
  input  wire logic                     cell_sync_en,
  input  wire logic                     cell_group_ctrl_a,
  input  wire logic                     cell_group_ctrl_b,
  input  wire lcr_mode_e                cell_mode,
  output logic                          lut_out,
  output logic                          cell_q,
  input  wire logic [LCR_DED_IN_W-1:0]  ded_in,
  input  wire logic [LCR_ROW_SRC_W-1:0] row_cell_in,
  input  wire logic [LCR_PCB_W*LCR_SRC_SEL_W-1:0] pcb_src_sel,
  input  wire logic [LCR_PCB_W-1:0]     pcb_src_inv,
  input  wire logic [LCR_PCB_SEL_W-1:0] pin_oe_sel,
  input  wire logic [LCR_PCB_SEL_W-1:0] pin_ce_sel,
  input  wire logic [LCR_PCB_SEL_W-1:0] pin_clr_sel,
  input  wire logic                     pin_oe_direct_use,
  input  wire logic                     pin_oe_direct,
  input  wire logic                     pin_ce_direct_use,
  input  wire logic                     pin_ce_direct,
  input  wire logic [1:0]               pin_clk_src,
  input  wire logic                     ded_clk_invert,
  input  wire logic [1:0]               ded_clk_pin,
  input  wire logic                     pin_d,
  input  wire logic                     chip_rst_n,
  output logic [LCR_PCB_W-1:0]          pcb_bus,
  output logic                          pcb_alloc_err,
  output logic                          pin_q,
  output logic                          pin_out,
  output logic                          pin_oe_n
);
  assign lut_out = lut_mask[lut_in];

  lcr_ctrl_if cell_ctl ();
  logic set_c;
  logic clr_c;
  logic inv_c;
  logic cell_d;

  always_comb begin
    set_c  = 1'b0;
    clr_c  = 1'b0;
    inv_c  = 1'b0;
    cell_d = lut_out;
    case (cell_mode)
      LCR_MODE_CLR: begin
        clr_c = cell_group_ctrl_a | cell_group_ctrl_b;
      end
      LCR_MODE_PRE: begin
        set_c = cell_group_ctrl_a;
      end
      LCR_MODE_PRE_CLR: begin
        set_c = cell_group_ctrl_a & ~cell_group_ctrl_b;
        clr_c = cell_group_ctrl_b;
      end
      LCR_MODE_LOAD_CLR: begin
        set_c = cell_group_ctrl_a & lut_in[3] & ~cell_group_ctrl_b;
        clr_c = cell_group_ctrl_b | (cell_group_ctrl_a & ~lut_in[3]);
      end
      LCR_MODE_LOAD_PRE: begin
        inv_c = 1'b1;
        clr_c = cell_group_ctrl_b | (cell_group_ctrl_a & lut_in[3]);
        set_c = cell_group_ctrl_a & ~lut_in[3] & ~cell_group_ctrl_b;
      end
      LCR_MODE_LOAD: begin
        set_c = cell_group_ctrl_a & lut_in[3];
        clr_c = cell_group_ctrl_a & ~lut_in[3];
      end
      default: begin
        clr_c = 1'b0;
      end
    endcase
  end

  assign cell_ctl.async_set = set_c;
  assign cell_ctl.async_clr = clr_c;
  assign cell_ctl.inv_io    = inv_c;

  lcr_cell_ff u_cell (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (clk_en),
    .sync_en (cell_sync_en),
    .d       (cell_d),
    .ctl     (cell_ctl),
    .q       (cell_q)
  );

  // pin inputs through two flops
  logic [LCR_DED_IN_W-1:0] ded_m_q;
  logic [LCR_DED_IN_W-1:0] ded_s_q;
  logic [1:0]              dclk_m_q;
  logic [1:0]              dclk_s_q;
  logic                    dclk_prev_q;
  logic [LCR_DED_IN_W-1:0] ded_m_d;
  logic [LCR_DED_IN_W-1:0] ded_s_d;
  logic [1:0]              dclk_m_d;
  logic [1:0]              dclk_s_d;
  logic                    dclk_prev_d;
  logic [LCR_PCB_W-1:0]    pcb_d;
  logic [LCR_PCB_W-1:0]    pcb_q;
  logic                    pin_q_d;
  logic                    pin_q_q;
  logic                    pin_oe_q;
  logic                    pin_oe_d;
  logic                    sel_clk;
  logic                    clk_edge;
  logic                    eff_ce;
  logic                    eff_oe;
  logic                    eff_clr;
  logic                    ded_clk_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < LCR_PCB_W; gi++) begin : g_pcb
      logic [LCR_SRC_SEL_W-1:0] s;
      logic                     raw;
      assign s = pcb_src_sel[gi*LCR_SRC_SEL_W +: LCR_SRC_SEL_W];
      assign raw = s[2] ? row_cell_in[s[1:0]] : ded_s_q[s[1:0]];
      assign pcb_d[gi] = raw ^ pcb_src_inv[gi];
    end
  endgenerate

  assign ded_clk_lvl = dclk_s_q[pin_clk_src[0]] ^ ded_clk_invert;

  always_comb begin
    ded_m_d     = ded_in;
    ded_s_d     = ded_m_q;
    dclk_m_d    = ded_clk_pin;
    dclk_s_d    = dclk_m_q;
    // clock from line 0 or 1, or from a dedicated clock pin when pin_clk_src[1] is set
    sel_clk  = pin_clk_src[1] ? ded_clk_lvl : pcb_q[pin_clk_src[0]];
    dclk_prev_d = sel_clk;
    clk_edge = sel_clk & ~dclk_prev_q;
    eff_ce   = pin_ce_direct_use ? pin_ce_direct : pcb_q[pin_ce_sel];
    eff_oe   = pin_oe_direct_use ? pin_oe_direct : pcb_q[pin_oe_sel];
    eff_clr  = pcb_q[pin_clr_sel];
    pin_q_d  = pin_q_q;
    pin_oe_d = eff_oe;
    if (eff_clr) begin
      pin_q_d = LCR_PIN_RST_VAL;
    end else if (clk_edge && eff_ce) begin
      pin_q_d = pin_d;
    end
    if (!chip_rst_n) begin
      pin_q_d  = LCR_PIN_RST_VAL;
      pin_oe_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ded_m_q     <= '0;
      ded_s_q     <= '0;
      dclk_m_q    <= '0;
      dclk_s_q    <= '0;
      dclk_prev_q <= 1'b0;
      pcb_q       <= '0;
      pin_q_q     <= LCR_PIN_RST_VAL;
      pin_oe_q    <= 1'b0;
    end else if (clk_en) begin
      ded_m_q     <= ded_m_d;
      ded_s_q     <= ded_s_d;
      dclk_m_q    <= dclk_m_d;
      dclk_s_q    <= dclk_s_d;
      dclk_prev_q <= dclk_prev_d;
      pcb_q       <= pcb_d;
      pin_q_q     <= pin_q_d;
      pin_oe_q    <= pin_oe_d;
    end
  end

  logic [LCR_PCB_W-1:0] oe_use;
  logic [LCR_PCB_W-1:0] ce_use;
  always_comb begin
    oe_use = '0;
    ce_use = '0;
    oe_use[pin_oe_sel] = ~pin_oe_direct_use;
    ce_use[pin_ce_sel] = ~pin_ce_direct_use;
  end
  assign pcb_alloc_err = (pin_oe_sel >= LCR_PCB_SEL_W'(LCR_PCB_W))
                       | (pin_ce_sel >= LCR_PCB_SEL_W'(LCR_PCB_W))
                       | (pin_clr_sel >= LCR_PCB_SEL_W'(LCR_PCB_W))
                       | ((|oe_use[LCR_PCB_W-1:LCR_MAX_OE]) & 1'b1)
                       | ((|ce_use[LCR_PCB_W-1:LCR_MAX_CE]) & 1'b1);

  assign pcb_bus  = pcb_q;
  assign pin_q    = pin_q_q;
  assign pin_out  = pin_q_q;
  assign pin_oe_n = ~pin_oe_q;
endmodule : lcr_top
